//--- bench/i2m_slave_model.sv
// Behavioural I2C slave at one address: acks writes, returns a fixed byte on reads.
// Assumes the bench resolves both lines as wired-AND with pull-ups.
`timescale 1ns/10ps
module i2m_slave_model
#(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] DATA = 8'hC3
)
(
  // Bus lines and stretch control
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic slow_i,
  output logic      scl_oe_o,
  output logic      sda_oe_o
);
  int         bit_n = 0;
  logic [7:0] sh_q  = 8'h00;
  logic [7:0] rx_q  = 8'h00;
  logic [7:0] ack_q = 8'h00;
  logic       act_q = 1'b0;
  logic       adr_q = 1'b0;
  logic       rd_q  = 1'b0;
  logic       cl_q  = 1'b0;
  logic       dl_q  = 1'b0;
  assign scl_oe_o = cl_q;
  assign sda_oe_o = dl_q;

  always @(negedge sda_i)
    if (scl_i)
    begin
      act_q = 1'b1;
      adr_q = 1'b1;
      bit_n = 0;
    end
  always @(posedge sda_i)
    if (scl_i)
      act_q = 1'b0;
  always @(posedge scl_i)
    if (act_q)
    begin
      if (bit_n < 8)
        sh_q = {sh_q[6:0], sda_i};
      else if (rd_q && !adr_q)
      begin
        ack_q = {ack_q[6:0], sda_i};
        act_q = !sda_i;
      end
      bit_n++;
    end
  always @(negedge scl_i)
    if (act_q)
    begin
      dl_q = 1'b0;
      if (bit_n == 8 && adr_q)
      begin
        rd_q  = sh_q[0];
        act_q = (sh_q[7:1] == ADDR);
        dl_q  = act_q;
      end
      else if (bit_n == 8 && !rd_q)
      begin
        rx_q = sh_q;
        dl_q = 1'b1;
      end
      if (bit_n == 9)
      begin
        bit_n = 0;
        adr_q = 1'b0;
      end
      if (act_q && rd_q && !adr_q && bit_n < 8)
        dl_q = !DATA[7 - bit_n];
      // Stretch only after SDA is settled, so no edge lands in SCL high
      if (slow_i)
      begin
        cl_q = 1'b1;
        #410 cl_q = 1'b0;
      end
    end
endmodule

//--- bench/i2m_top_props.sv
// Port checks of the I2C master: pin levels, SCL phase lengths, Stop order, interrupt.
// Assumes software sets an SCL period of 10 core clocks before any traffic.
`timescale 1ns/10ps
`include "i2m_defs.svh"
module i2m_top_props
(
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  // Wishbone
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Interrupt and pins
  input wire logic        irq_o,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o
);
  localparam int PER = 10;
  localparam int HP  = 5;
  logic [7:0] lo_q, hi_q, sd_q;
  logic [3:0] pi_q;
  logic [2:0] msk_q;
  logic       ah_q, sda_p_q;
  logic       rel_w, start_w;
  // Low pulse index within a byte: 8 is the acknowledge clock
  assign rel_w   = !scl_oe_o && lo_q != 8'h00;
  assign start_w = sda_p_q && !sda_i && scl_i;

  always_ff @(posedge core_clk_i)
    if (srst_i)
    begin
      {lo_q, hi_q, sd_q, pi_q, msk_q, ah_q} <= '0;
      sda_p_q <= 1'b1;
    end
    else
    begin
      lo_q    <= scl_oe_o ? lo_q + 8'h01 : 8'h00;
      hi_q    <= (scl_i && !scl_oe_o) ? hi_q + 8'h01 : 8'h00;
      sd_q    <= sda_oe_o ? sd_q + 8'h01 : 8'h00;
      sda_p_q <= sda_i;
      ah_q    <= rel_w ? (pi_q == 4'h8) : (ah_q && !scl_oe_o);
      if (start_w)
        pi_q <= 4'h0;
      else if (rel_w)
        pi_q <= (pi_q == 4'h8) ? 4'h0 : pi_q + 4'h1;
      if (wb_ack_o && wb_we_i && wb_adr_i == `I2M_OFS_IRQ_MSK)
        msk_q <= wb_dat_i[2:0];
    end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence scl_seen_s;
    $past(scl_i, 1) && $past(scl_i, 2);
  endsequence
  sequence stop_s;
    !sda_p_q && sda_i && scl_i;
  endsequence

  pins_low_only_a: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  reset_idle_a: assert property ($fell(srst_i) |-> !scl_oe_o && !sda_oe_o && !irq_o)
    else $error("outputs active after reset");
  bit_low_a: assert property (rel_w && pi_q != 4'h8 |-> lo_q >= HP)
    else $error("bit low phase too short");
  ack_low_a: assert property (rel_w && pi_q == 4'h8 |-> lo_q >= PER)
    else $error("acknowledge low phase too short");
  ack_high_a: assert property ($rose(scl_oe_o) && ah_q |-> hi_q inside {[PER:PER + 6]})
    else $error("acknowledge high phase wrong length");
  stop_order_a: assert property ($fell(sda_oe_o) && scl_i |-> scl_seen_s ##0 sd_q >= HP + 1)
    else $error("stop released out of order");
  stop_flag_a: assert property (stop_s ##0 msk_q[0] |-> ##[1:6] irq_o)
    else $error("stop not flagged");
  irq_mask_a: assert property (irq_o |-> msk_q != 3'h0)
    else $error("interrupt while masked");
  sda_hold_a: assert property ($rose(scl_oe_o) |-> $stable(sda_oe_o))
    else $error("data moved with clock fall");
endmodule

bind i2m_top i2m_top_props chk_u
(
  .core_clk_i(core_clk_i), .srst_i(srst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
);

//--- bench/i2m_top_tb.sv
// Self-checking bench of the I2C master with one slave model on the wires.
// Assumes checker and slave model are compiled before it.
`timescale 1ns/10ps
`include "i2m_defs.svh"
module i2m_top_tb;
  logic        clk, rst, cyc, stb, we, slow;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic        ack, irq, m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe;
  wire         scl_w, sda_w;
  int          mismatches, checked;
  // Pull-ups: a released line reads high
  assign scl_w = !(m_scl_oe || s_scl_oe);
  assign sda_w = !(m_sda_oe || s_sda_oe);

  i2m_top dut
  (
    .core_clk_i(clk), .srst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .scl_i(scl_w), .scl_o(), .scl_oe_o(m_scl_oe), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(m_sda_oe)
  );
  i2m_slave_model slv
  (
    .scl_i(scl_w), .sda_i(sda_w), .slow_i(slow), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    chk(ack, 1'b0, "ack drop");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    wb(1'b0, a, 16'h0000);
    chk(q & m, e, nm);
  endtask

  task automatic xfer(input logic [7:0] a, input logic [7:0] n, input logic [7:0] c);
    int k;
    wb(1'b1, `I2M_OFS_IRQ_ST, 16'h0007);
    wb(1'b1, `I2M_OFS_ADB0, {8'h00, a});
    wb(1'b1, `I2M_OFS_COUNT, {8'h00, n});
    wb(1'b1, `I2M_OFS_CTRL, {8'h00, c});
    k = 0;
    while (irq !== 1'b1 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    chk(irq, 1, "stop interrupt");
  endtask

  task automatic t_regs();
    rd(`I2M_OFS_PERIOD, 32'h0000_FFFF, 32'h0000_01F4, "period reset");
    rd(`I2M_OFS_IRQ_MSK, 32'hFFFF_FFFF, 32'h0000_0000, "mask reset");
    wb(1'b1, `I2M_OFS_STATUS, 16'h007F);
    rd(`I2M_OFS_STATUS, 32'h0000_00FF, 32'h0000_0080, "status");
    rd(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    wb(1'b1, `I2M_OFS_PERIOD, 16'h000A);
    wb(1'b1, `I2M_OFS_IRQ_MSK, 16'h0001);
  endtask

  task automatic t_write();
    slow <= 1'b1;
    wb(1'b1, `I2M_OFS_TXDATA, 16'h0096);
    xfer(8'h54, 8'h01, 8'h03);
    chk(slv.rx_q, 8'h96, "slave byte");
    rd(`I2M_OFS_STATUS, 32'h0000_0010, 32'h0000_0000, "write direction");
    wb(1'b1, `I2M_OFS_IRQ_MSK, 16'h0000);
    chk(irq, 0, "masked interrupt");
    rd(`I2M_OFS_IRQ_ST, 32'h0000_0001, 32'h0000_0001, "stop flag");
    wb(1'b1, `I2M_OFS_IRQ_ST, 16'h0007);
    rd(`I2M_OFS_IRQ_ST, 32'h0000_0007, 32'h0000_0000, "cleared flags");
    wb(1'b1, `I2M_OFS_IRQ_MSK, 16'h0001);
  endtask

  task automatic t_read();
    slow <= 1'b0;
    xfer(8'h55, 8'h02, 8'h0B);
    rd(`I2M_OFS_RXDATA, 32'h0000_00FF, 32'h0000_00C3, "received byte");
    rd(`I2M_OFS_STATUS, 32'h0000_0010, 32'h0000_0010, "read direction");
    xfer(8'h55, 8'h01, 8'h07);
    chk(slv.ack_q[2:0], 3'b010, "acknowledge bits");
  endtask

  task automatic t_nack();
    xfer(8'h40, 8'h01, 8'h03);
    rd(`I2M_OFS_IRQ_ST, 32'h0000_0004, 32'h0000_0004, "address refused");
  endtask

  initial
  begin
    #200000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    mismatches = 0;
    checked    = 0;
    rst  = 1'b1;
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 8'h00;
    wdat = 32'h0000_0000;
    slow = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_regs();
    t_write();
    t_read();
    t_nack();
    end_of_test();
  end
endmodule

//--- hdl/i2m_sense.sv
// Two-flop sampler of the SCL/SDA pins with Start and Stop detection.
// Assumes pins are asynchronous to core_clk_i.
`timescale 1ns/10ps
module i2m_sense
  import i2m_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Toward the core
  i2m_line_if.sense line
);

  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic       sda_prev_q;

  // Second stage only is read by logic
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meta_q     <= 2'h3;
      sync_q     <= 2'h3;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      meta_q     <= {scl_i, sda_i};
      sync_q     <= meta_q;
      sda_prev_q <= sync_q[0];
    end
  end

  assign line.scl_s   = sync_q[1];
  assign line.sda_s   = sync_q[0];
  assign line.stop_p  = sync_q[1] & sync_q[0] & ~sda_prev_q;  // [RL11]
  assign line.start_p = sync_q[1] & ~sync_q[0] & sda_prev_q;

endmodule

//--- hdl/i2m_timer.sv
// Down counter timing SCL periods and half periods in core clocks.
// Assumes the core loads it on every state change.
`timescale 1ns/10ps
module i2m_timer
  import i2m_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Toward the core
  i2m_line_if.timer line
);

  logic [15:0] cnt_q;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      cnt_q <= 16'h0000;
    else if (line.tmr_load)
      cnt_q <= line.tmr_len - 16'h0001;
    else if (cnt_q != 16'h0000)
      cnt_q <= cnt_q - 16'h0001;
  end

  // Done must not look at the load, which itself follows from done
  assign line.tmr_done = cnt_q == 16'h0000;

endmodule

//--- hdl/i2m_top.sv
// I2C master byte engine: acknowledge phase, automatic Stop, status and interrupts.
// Assumes a classic Wishbone master on core_clk_i and pull-ups on SCL and SDA.
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`include "i2m_defs.svh"
module i2m_top
  import i2m_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq_o,
  // I2C pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);

  i2m_line_if line ();

  i2m_sense u_sense
  (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .line       (line)
  );

  i2m_timer u_timer
  (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .line       (line)
  );

  // Registers
  logic [7:0]    ctrl_q;
  logic          go_q;
  logic [7:0]    adb0_q;
  logic [7:0]    count_q;
  logic [7:0]    txdata_q;
  logic [7:0]    rxdata_q;
  logic [15:0]   period_q;
  logic [2:0]    irq_st_q;
  logic [2:0]    irq_msk_q;
  logic          ack_q;
  logic [31:0]   rdata_q;
  logic          bus_free_q;
  logic          read_q;
  logic          data_q;

  // Engine state
  i2m_state_type state_q;
  i2m_state_type state_d;
  logic [7:0]    shift_q;
  logic [2:0]    bit_q;
  logic          addr_ph_q;
  logic          rx_q;
  logic          nack_q;

  // Bus decode
  logic          req;
  logic          wr_en;
  logic          wr_lo;
  logic          wr_hi;
  logic          hit_ctrl;
  logic          hit_adb0;
  logic          hit_count;
  logic          hit_tx;
  logic          hit_period;
  logic          hit_irq_st;
  logic          hit_irq_msk;
  logic [31:0]   rd_mux;
  logic [7:0]    status_w;

  assign req         = wb_cyc_i & wb_stb_i;
  assign wr_en       = req & wb_we_i & ack_q;
  assign wr_lo       = wr_en & wb_sel_i[0];
  assign wr_hi       = wr_en & wb_sel_i[1];
  assign hit_ctrl    = wb_adr_i == `I2M_OFS_CTRL;
  assign hit_adb0    = wb_adr_i == `I2M_OFS_ADB0;
  assign hit_count   = wb_adr_i == `I2M_OFS_COUNT;
  assign hit_tx      = wb_adr_i == `I2M_OFS_TXDATA;
  assign hit_period  = wb_adr_i == `I2M_OFS_PERIOD;
  assign hit_irq_st  = wb_adr_i == `I2M_OFS_IRQ_ST;
  assign hit_irq_msk = wb_adr_i == `I2M_OFS_IRQ_MSK;

  logic          enable;
  logic          mst_act;
  assign enable  = ctrl_q[`I2M_CTRL_EN];
  assign mst_act = state_q != I2M_IDLE;

  // Status is read only; no write path exists [RL13]
  assign status_w = {bus_free_q, 1'b0, mst_act, read_q, data_q, 3'h0};

  assign rd_mux =
    (wb_adr_i == `I2M_OFS_CTRL)    ? {24'h00_0000, ctrl_q} :
    (wb_adr_i == `I2M_OFS_STATUS)  ? {24'h00_0000, status_w} :
    (wb_adr_i == `I2M_OFS_ADB0)    ? {24'h00_0000, adb0_q} :
    (wb_adr_i == `I2M_OFS_COUNT)   ? {24'h00_0000, count_q} :
    (wb_adr_i == `I2M_OFS_TXDATA)  ? {24'h00_0000, txdata_q} :
    (wb_adr_i == `I2M_OFS_RXDATA)  ? {24'h00_0000, rxdata_q} :
    (wb_adr_i == `I2M_OFS_PERIOD)  ? {16'h0000, period_q} :
    (wb_adr_i == `I2M_OFS_IRQ_ST)  ? {29'h0000_0000, irq_st_q} :
    (wb_adr_i == `I2M_OFS_IRQ_MSK) ? {29'h0000_0000, irq_msk_q} :
    32'h0000_0000;

  // One wait state: ack in the cycle after the request, dropped the next
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= req & ~ack_q;
      rdata_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Engine decisions
  logic          half_w;
  logic          last_w;
  logic          ackv_w;
  logic          drv_ack;
  logic [7:0]    cnt_next;
  logic          stop_now;
  logic          byte_end;
  logic          ack_end;
  logic [7:0]    shift_in;

  assign half_w   = (period_q[15:1] == 15'h0000) ? 1'b1 : 1'b0;
  assign last_w   = count_q == 8'h01;
  // Receiver answers with the setting software chose [RL2] [RL3]
  assign ackv_w   = last_w ? ctrl_q[`I2M_CTRL_ACKEND] : ctrl_q[`I2M_CTRL_ACKDAT];
  assign drv_ack  = rx_q & ~addr_ph_q & ~ackv_w;
  assign cnt_next = addr_ph_q ? count_q : count_q - 8'h01;
  assign shift_in = {shift_q[6:0], line.sda_s};
  assign byte_end = (state_q == I2M_BHIGH) & line.tmr_done & (bit_q == 3'h0);
  assign ack_end  = (state_q == I2M_AHIGH) & line.tmr_done;
  // Stop once the counter reaches zero or a sent byte is refused [RL7]
  assign stop_now = (cnt_next == 8'h00) | (~rx_q & line.sda_s) | (addr_ph_q & line.sda_s);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      I2M_IDLE:
        if (go_q & enable & line.scl_s & line.sda_s)
          state_d = I2M_START;
      I2M_START:
        if (line.tmr_done)
          state_d = I2M_BLOW;
      I2M_BLOW:
        if (line.tmr_done)
          state_d = I2M_BREL;
      I2M_BREL:
        if (line.scl_s)
          state_d = I2M_BHIGH;
      I2M_BHIGH:
        if (line.tmr_done)
          state_d = (bit_q == 3'h0) ? I2M_ALOW : I2M_BLOW;  // [RL1]
      I2M_ALOW:
        if (line.tmr_done)
          state_d = I2M_AREL;                              // [RL4]
      I2M_AREL:
        if (line.scl_s)
          state_d = I2M_AHIGH;                             // [RL5]
      I2M_AHIGH:
        if (line.tmr_done)
          state_d = stop_now ? I2M_PLOW : I2M_BLOW;        // [RL6] [RL7]
      I2M_PLOW:
        if (line.tmr_done)
          state_d = I2M_PREL;                              // [RL9]
      I2M_PREL:
        if (line.scl_s)
          state_d = I2M_PSDA;                              // [RL9]
      I2M_PSDA:
        if (line.tmr_done)
          state_d = I2M_IDLE;
    endcase
    if (!enable)
      state_d = I2M_IDLE;                                  // [RL13]
  end

  // Each phase restarts the timer; ack phases last a full period
  assign line.tmr_load = state_d != state_q;
  assign line.tmr_len  =
    (state_d == I2M_ALOW || state_d == I2M_AHIGH) ? period_q :
    half_w ? 16'h0001 : {1'b0, period_q[15:1]};

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      state_q <= I2M_IDLE;
    else
      state_q <= state_d;
  end

  // Byte engine datapath
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      shift_q   <= `I2M_RST_BYTE;
      bit_q     <= 3'h7;
      addr_ph_q <= 1'b0;
      rx_q      <= 1'b0;
      nack_q    <= 1'b0;
    end
    else if (state_q == I2M_IDLE)
    begin
      shift_q   <= adb0_q;
      bit_q     <= 3'h7;
      addr_ph_q <= 1'b1;
      rx_q      <= 1'b0;
      nack_q    <= 1'b0;
    end
    else if (state_q == I2M_BHIGH && line.tmr_done)
    begin
      shift_q <= shift_in;
      bit_q   <= bit_q - 3'h1;
    end
    else if (ack_end)
    begin
      nack_q    <= ~(rx_q & ~addr_ph_q) & line.sda_s;
      addr_ph_q <= 1'b0;
      if (addr_ph_q)
        rx_q <= adb0_q[0];
      // A receiver releases SDA by shifting ones out
      shift_q <= ((addr_ph_q & adb0_q[0]) | (rx_q & ~addr_ph_q)) ? 8'hFF : txdata_q;
    end
  end

  // Pins only pull low or float [RL14]
  logic scl_low;
  logic sda_low;
  assign scl_low =
    (state_q == I2M_BLOW) | (state_q == I2M_ALOW) | (state_q == I2M_PLOW);
  assign sda_low =
    ((state_q == I2M_BLOW || state_q == I2M_BREL || state_q == I2M_BHIGH) & ~shift_q[7]) |
    ((state_q == I2M_ALOW || state_q == I2M_AREL || state_q == I2M_AHIGH) & drv_ack) |
    (state_q == I2M_START) | (state_q == I2M_PLOW) | (state_q == I2M_PREL);  // [RL8] [RL10]

  logic scl_oe_q;
  logic sda_oe_q;
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      scl_oe_q <= scl_low;
      sda_oe_q <= (scl_low & ~scl_oe_q) ? sda_oe_q : sda_low;  // After SCL falls [RL1]
    end
  end

  assign scl_o    = 1'b0;  // [RL14]
  assign sda_o    = 1'b0;  // [RL14]
  assign scl_oe_o = scl_oe_q;
  assign sda_oe_o = sda_oe_q;

  // Software registers
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_q    <= `I2M_RST_CTRL;
      adb0_q    <= `I2M_RST_BYTE;
      txdata_q  <= `I2M_RST_BYTE;
      period_q  <= 16'(`I2M_SCL_PERIOD_CYC);
      irq_msk_q <= 3'h0;
    end
    else
    begin
      if (wr_lo && hit_ctrl)
        ctrl_q <= wb_dat_i[7:0] & 8'h0D;
      if (wr_lo && hit_adb0)
        adb0_q <= wb_dat_i[7:0];
      if (wr_lo && hit_tx)
        txdata_q <= wb_dat_i[7:0];
      if (wr_lo && hit_period)
        period_q[7:0] <= wb_dat_i[7:0];
      if (wr_hi && hit_period)
        period_q[15:8] <= wb_dat_i[15:8];
      if (wr_lo && hit_irq_msk)
        irq_msk_q <= wb_dat_i[2:0];
    end
  end

  // Go request held until the engine takes it
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      go_q <= 1'b0;
    else if (wr_lo && hit_ctrl && wb_dat_i[`I2M_CTRL_GO])
      go_q <= 1'b1;
    else if (state_q == I2M_START || !enable)
      go_q <= 1'b0;
  end

  // Byte counter: written by software, counted down by data bytes
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      count_q <= `I2M_RST_BYTE;
    else if (ack_end && !addr_ph_q)
      count_q <= cnt_next;
    else if (wr_lo && hit_count)
      count_q <= wb_dat_i[7:0];
  end

  // Received byte and module status
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      rxdata_q   <= `I2M_RST_BYTE;
      read_q     <= 1'b0;
      data_q     <= 1'b0;
      bus_free_q <= 1'b1;
    end
    else
    begin
      if (byte_end && rx_q && !addr_ph_q)
        rxdata_q <= shift_in;
      if (ack_end)
        data_q <= ~addr_ph_q;
      if (ack_end && addr_ph_q && !line.sda_s)
        read_q <= adb0_q[0];                               // [RL12]
      if (line.start_p)
        bus_free_q <= 1'b0;
      else if (line.stop_p)
        bus_free_q <= 1'b1;
    end
  end

  // Sticky interrupt flags: hardware set wins over a write-one clear
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set[`I2M_IRQ_STOP] = line.stop_p;             // [RL11]
  assign irq_set[`I2M_IRQ_BYTE] = ack_end & ~addr_ph_q;
  assign irq_set[`I2M_IRQ_NACK] = ack_end & ~(rx_q & ~addr_ph_q) & line.sda_s;
  assign irq_clr = (wr_lo && hit_irq_st) ? wb_dat_i[2:0] : 3'h0;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      irq_st_q <= 3'h0;
    else
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
  end

  assign irq_o = |(irq_st_q & irq_msk_q);

endmodule

//--- include/i2m_defs.svh
// Constants of the I2C master acknowledge / stop block: offsets, fields, resets, timing.
// Assumes a 50 MHz core clock and a 32-bit classic Wishbone register bus.
//
// How it works
// RL1: After each address or data byte the master runs an acknowledge phase, SCL held low first.
// RL2: In that phase a receiving master puts its ack setting, or the end-count setting, on SDA.
// RL3: Software clears the ack setting for ACK and sets it before the phase for NACK.
// RL4: With the ack bit on SDA, SCL stays low one full SCL period and is then released.
// RL5: After release the master waits to see SCL high, then times another full period.
// RL6: When that second period ends the master pulls SCL low again.
// RL7: A Stop is issued by itself when a sequence ends with the byte counter at zero.
// RL8: A Stop begins with SCL kept low after the last byte and SDA pulled low.
// RL9: Half an SCL period later SCL is released and the master waits to see it high.
// RL10: Once SCL is seen high the master releases SDA so it rises with SCL high.
// RL11: SDA rising while SCL is high sets the stop-detected flag.
// RL12: The direction status bit holds the read/write bit of the last acknowledged address.
// RL13: Software returns the state machine to idle with the enable bit, status is read only.
// RL14: SCL and SDA are only pulled low or released, never driven high.
`ifndef I2M_DEFS_SVH
`define I2M_DEFS_SVH

// Register byte offsets
`define I2M_OFS_CTRL    8'h00
`define I2M_OFS_STATUS  8'h04
`define I2M_OFS_ADB0    8'h08
`define I2M_OFS_COUNT   8'h0C
`define I2M_OFS_TXDATA  8'h10
`define I2M_OFS_RXDATA  8'h14
`define I2M_OFS_PERIOD  8'h18
`define I2M_OFS_IRQ_ST  8'h1C
`define I2M_OFS_IRQ_MSK 8'h20

// Control fields
`define I2M_CTRL_EN      0
`define I2M_CTRL_GO      1
`define I2M_CTRL_ACKDAT  2
`define I2M_CTRL_ACKEND  3

// Module status fields
`define I2M_ST_BUSFREE   7
`define I2M_ST_SLVACT    6
`define I2M_ST_MSTACT    5
`define I2M_ST_READ      4
`define I2M_ST_DATA      3

// Interrupt status fields
`define I2M_IRQ_STOP     0
`define I2M_IRQ_BYTE     1
`define I2M_IRQ_NACK     2

// Reset values
`define I2M_RST_CTRL     8'h00
`define I2M_RST_STATUS   8'h00
`define I2M_RST_BYTE     8'h00

// Timing
`define I2M_CLK_NS        20
`define I2M_SCL_PERIOD_NS 10000
`define I2M_SCL_PERIOD_CYC ((`I2M_SCL_PERIOD_NS) / (`I2M_CLK_NS))

`endif

//--- include/i2m_line_if.sv
// Carrier between the core, its line sampler and its period timer.
// Assumes one core clock drives all three parties.
`timescale 1ns/10ps
interface i2m_line_if;
  logic        scl_s;
  logic        sda_s;
  logic        stop_p;
  logic        start_p;
  logic        tmr_load;
  logic [15:0] tmr_len;
  logic        tmr_done;

  modport sense (output scl_s, sda_s, stop_p, start_p);
  modport timer (input tmr_load, tmr_len, output tmr_done);
  modport core  (input scl_s, sda_s, stop_p, start_p, tmr_done, output tmr_load, tmr_len);
endinterface

//--- include/i2m_pkg.sv
// Types shared by the I2C master block.
// Assumes nothing beyond a SystemVerilog tool.
package i2m_pkg;

  typedef enum logic [3:0]
  {
    I2M_IDLE,
    I2M_START,
    I2M_BLOW,
    I2M_BREL,
    I2M_BHIGH,
    I2M_ALOW,
    I2M_AREL,
    I2M_AHIGH,
    I2M_PLOW,
    I2M_PREL,
    I2M_PSDA
  } i2m_state_type;

endpackage
